// File: logic/xint_pkg.sv
// package for the extra external interrupt and port block
// assumes an 8-bit special-function bus driven by the cpu core on clock_i
package xint_pkg;

	// special-function byte addresses
	localparam logic [7:0] XINT_ADDR_CONTROL   = 8'hC0;
	localparam logic [7:0] XINT_ADDR_PORT      = 8'hD8;
	// bit addresses share the upper five bits with the byte address
	localparam logic [4:0] XINT_BITBASE_CTRL   = 5'h18;
	localparam logic [4:0] XINT_BITBASE_PORT   = 5'h1B;

	// extra_ext_int_control field positions
	localparam int unsigned XINT_EXT_IRQ_INPUT_2_TRIG_POS = 0;
	localparam int unsigned XINT_EXT_IRQ_INPUT_2_FLAG_POS = 1;
	localparam int unsigned XINT_EXT_IRQ_INPUT_2_EN_POS   = 2;
	localparam int unsigned XINT_EXT_IRQ_INPUT_2_PRIO_POS = 3;
	localparam int unsigned XINT_EXT_IRQ_INPUT_3_TRIG_POS = 4;
	localparam int unsigned XINT_EXT_IRQ_INPUT_3_FLAG_POS = 5;
	localparam int unsigned XINT_EXT_IRQ_INPUT_3_EN_POS   = 6;
	localparam int unsigned XINT_EXT_IRQ_INPUT_3_PRIO_POS = 7;

	// interrupt_enable_reg and timer_control_reg field positions
	localparam int unsigned XINT_IE_ALL_POS    = 7;
	localparam int unsigned XINT_TC_EXT0_POS   = 0;
	localparam int unsigned XINT_TC_EXT1_POS   = 2;

	// extra port wiring: pin 2 feeds interrupt 2, pin 3 feeds interrupt 3
	localparam int unsigned XINT_PORT_EXT_IRQ_INPUT_2_PIN = 2;
	localparam int unsigned XINT_PORT_EXT_IRQ_INPUT_3_PIN = 3;

	// reset values
	localparam logic [3:0] XINT_RST_PORT       = 4'hF;
	localparam logic [1:0] XINT_RST_CTRL2      = 2'h0;
	localparam logic [7:0] XINT_RST_BYTE       = 8'h00;
	localparam logic [3:0] XINT_PORT_UNUSED    = 4'h0;

	// source numbering is also the polling order inside one level
	typedef enum logic [2:0] {
		XINT_SRC_EXT0   = 3'h0,
		XINT_SRC_TMR0   = 3'h1,
		XINT_SRC_EXT1   = 3'h2,
		XINT_SRC_TMR1   = 3'h3,
		XINT_SRC_SERIAL = 3'h4,
		XINT_SRC_TMR2   = 3'h5,
		XINT_SRC_EXT2   = 3'h6,
		XINT_SRC_EXT3   = 3'h7
	} xint_src_t;

	// vector address of each source
	function automatic logic [7:0] xint_vector(input logic [2:0] src);
		logic [7:0] v;
		v = 8'h03;
		unique case (src)
			XINT_SRC_EXT0:   v = 8'h03;
			XINT_SRC_TMR0:   v = 8'h0B;
			XINT_SRC_EXT1:   v = 8'h13;
			XINT_SRC_TMR1:   v = 8'h1B;
			XINT_SRC_SERIAL: v = 8'h23;
			XINT_SRC_TMR2:   v = 8'h2B;
			XINT_SRC_EXT2:   v = 8'h33;
			XINT_SRC_EXT3:   v = 8'h3B;
		endcase
		return v;
	endfunction

	// lowest set index wins, matching the fixed polling order
	function automatic logic [2:0] xint_first(input logic [7:0] pend);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (pend[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

endpackage

// File: logic/xint_trig_if.sv
// carrier between the controller and one trigger detector
// assumes all signals belong to clock_i
`timescale 1ns/100ps
`default_nettype none
interface xint_trig_if;
	logic pin_n;
	logic edge_mode;
	logic sw_we;
	logic sw_val;
	logic svc_clr;
	logic flag;

	modport ctrl (output pin_n, output edge_mode, output sw_we, output sw_val,
		output svc_clr, input flag);
	modport trig (input pin_n, input edge_mode, input sw_we, input sw_val,
		input svc_clr, output flag);
endinterface
`default_nettype wire

// File: logic/xint_trig.sv
// falling-edge or low-level detector holding one request flag
// assumes the pin is already synchronous to clock_i
`timescale 1ns/100ps
`default_nettype none
module xint_trig
	import xint_pkg::*;
(
	input  wire logic  clock_i,
	input  wire logic  arst_n_i,
	xint_trig_if.trig  bus
);
	typedef struct packed {
		logic prev_n;
		logic flag;
	} xint_trig_st_t;

	xint_trig_st_t st;
	xint_trig_st_t next_st;
	logic          fall;

	// edge flag: the set beats a software or service clear in the same cycle
	always_comb begin
		next_st = st;
		fall = st.prev_n & ~bus.pin_n;
		next_st.prev_n = bus.pin_n;
		if (bus.edge_mode) begin
			if (fall) begin
				next_st.flag = 1'b1;
			end else if (bus.svc_clr) begin
				next_st.flag = 1'b0;
			end else if (bus.sw_we) begin
				next_st.flag = bus.sw_val;
			end
		end else begin
			// not latched: the pin must stay low until serviced
			next_st.flag = ~bus.pin_n;
		end
	end

	// idle pin level is high, so no spurious edge after reset
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '{prev_n: 1'b1, flag: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign bus.flag = st.flag;
endmodule // xint_trig
`default_nettype wire

// File: logic/xint_top.sv
// extra external interrupts, extra 4-bit port and eight-source arbiter
// assumes the core drives the special-function bus synchronous to clock_i,
// and that the core tracks in-service levels and nesting itself
//
// Operation
// - control register sits at C0, bit-addressable
// - control bits: prio, enable, flag, trigger per input
// - priority bit set means high level
// - extra inputs request only while enabled
// - trigger bit set: falling edge, clear: low level
// - edge flag set by hardware, cleared on vectoring
// - eight fixed vector addresses, 03 through 3B
// - fixed polling order inside each level
// - first six enables from core enable register
// - port at D8, bit-addressable, quasi-bidirectional
// - only low four port bits usable
// - port bits 2 and 3 double as interrupts
`timescale 1ns/100ps
`default_nettype none
module xint_top
	import xint_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        arst_n_i,
	// special-function byte access
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic        sfr_wr_i,
	input  wire logic        sfr_rd_i,
	input  wire logic [7:0]  sfr_wdata_i,
	output logic      [7:0]  sfr_rdata_o,
	// single-bit access
	input  wire logic [7:0]  bit_addr_i,
	input  wire logic        bit_wr_i,
	input  wire logic        bit_wdata_i,
	// standard interrupt sources and core registers
	input  wire logic        ext0_n_i,
	input  wire logic        ext1_n_i,
	input  wire logic [3:0]  other_flag_i,
	input  wire logic [7:0]  interrupt_enable_reg_i,
	input  wire logic [7:0]  timer_control_reg_i,
	input  wire logic [5:0]  std_priority_i,
	output logic      [1:0]  ext01_flag_o,
	// request towards the core
	output logic             irq_req_o,
	output logic             irq_high_o,
	output logic      [2:0]  irq_src_o,
	output logic      [7:0]  irq_vector_o,
	input  wire logic        irq_ack_i,
	// extra port pins
	input  wire logic [3:0]  extra_io_port_i,
	output logic      [3:0]  extra_io_port_o,
	output logic      [3:0]  extra_io_port_oe_o
);
	typedef struct packed {
		logic [1:0] prio;
		logic [1:0] en;
		logic [1:0] trig;
		logic [3:0] latch;
		logic [3:0] drive_low;
		logic [7:0] rdata;
		logic [1:0] ext01;
		logic       req;
		logic       high;
		logic [2:0] src;
		logic [7:0] vec;
	} xint_top_st_t;

	xint_top_st_t st;
	xint_top_st_t next_st;

	xint_trig_if  trig_bus [4] ();
	logic [3:0]   flags;
	logic [3:0]   pin_n;
	logic [3:0]   edge_mode;
	logic [3:0]   sw_we;
	logic [3:0]   sw_val;
	logic         ctrl_byte_wr;
	logic         port_byte_wr;
	logic         ctrl_bit_wr;
	logic         port_bit_wr;
	logic [2:0]   bit_sel;
	logic [7:0]   ctrl_view;
	logic [7:0]   pend;
	logic [7:0]   hi_pend;
	logic [7:0]   prio_all;
	logic [7:0]   en_all;
	logic [7:0]   flag_all;
	logic [2:0]   win;

	// access decode; a bit address carries its byte address in the top five bits
	assign ctrl_byte_wr = sfr_wr_i && (sfr_addr_i == XINT_ADDR_CONTROL);
	assign port_byte_wr = sfr_wr_i && (sfr_addr_i == XINT_ADDR_PORT);
	assign ctrl_bit_wr  = bit_wr_i && (bit_addr_i[7:3] == XINT_BITBASE_CTRL);
	assign port_bit_wr  = bit_wr_i && (bit_addr_i[7:3] == XINT_BITBASE_PORT);
	assign bit_sel      = bit_addr_i[2:0];

	// trigger inputs: ext0 and ext1 pins, then port pins 2 and 3
	assign pin_n[0] = ext0_n_i;
	assign pin_n[1] = ext1_n_i;
	assign pin_n[2] = extra_io_port_i[XINT_PORT_EXT_IRQ_INPUT_2_PIN];
	assign pin_n[3] = extra_io_port_i[XINT_PORT_EXT_IRQ_INPUT_3_PIN];
	assign edge_mode[0] = timer_control_reg_i[XINT_TC_EXT0_POS];
	assign edge_mode[1] = timer_control_reg_i[XINT_TC_EXT1_POS];
	assign edge_mode[3:2] = st.trig;

	// software access to the two extra flags; ext0/ext1 flags belong to the core
	assign sw_we[1:0]  = 2'h0;
	assign sw_val[1:0] = 2'h0;
	assign sw_we[2]  = ctrl_byte_wr || (ctrl_bit_wr && bit_sel == 3'(XINT_EXT_IRQ_INPUT_2_FLAG_POS));
	assign sw_we[3]  = ctrl_byte_wr || (ctrl_bit_wr && bit_sel == 3'(XINT_EXT_IRQ_INPUT_3_FLAG_POS));
	assign sw_val[2] = ctrl_byte_wr ? sfr_wdata_i[XINT_EXT_IRQ_INPUT_2_FLAG_POS] : bit_wdata_i;
	assign sw_val[3] = ctrl_byte_wr ? sfr_wdata_i[XINT_EXT_IRQ_INPUT_3_FLAG_POS] : bit_wdata_i;

	// one detector per external source
	for (genvar g = 0; g < 4; g++) begin : g_trig
		assign trig_bus[g].pin_n     = pin_n[g];
		assign trig_bus[g].edge_mode = edge_mode[g];
		assign trig_bus[g].sw_we     = sw_we[g];
		assign trig_bus[g].sw_val    = sw_val[g];
		// the acknowledged source is the one shown on irq_src_o
		assign trig_bus[g].svc_clr   = irq_ack_i && st.req &&
			(st.src == (g == 0 ? XINT_SRC_EXT0 : g == 1 ? XINT_SRC_EXT1 :
			g == 2 ? XINT_SRC_EXT2 : XINT_SRC_EXT3));
		assign flags[g] = trig_bus[g].flag;
		xint_trig u_trig (
			.clock_i  (clock_i),
			.arst_n_i (arst_n_i),
			.bus      (trig_bus[g])
		);
	end

	// register image as software reads it
	always_comb begin
		ctrl_view = XINT_RST_BYTE;
		ctrl_view[XINT_EXT_IRQ_INPUT_2_TRIG_POS] = st.trig[0];
		ctrl_view[XINT_EXT_IRQ_INPUT_2_FLAG_POS] = flags[2];
		ctrl_view[XINT_EXT_IRQ_INPUT_2_EN_POS]   = st.en[0];
		ctrl_view[XINT_EXT_IRQ_INPUT_2_PRIO_POS] = st.prio[0];
		ctrl_view[XINT_EXT_IRQ_INPUT_3_TRIG_POS] = st.trig[1];
		ctrl_view[XINT_EXT_IRQ_INPUT_3_FLAG_POS] = flags[3];
		ctrl_view[XINT_EXT_IRQ_INPUT_3_EN_POS]   = st.en[1];
		ctrl_view[XINT_EXT_IRQ_INPUT_3_PRIO_POS] = st.prio[1];
	end

	// eight sources in polling order
	assign flag_all = {flags[3], flags[2], other_flag_i[3:1], flags[1],
		other_flag_i[0], flags[0]};
	assign en_all   = {st.en, interrupt_enable_reg_i[5:0]};
	assign prio_all = {st.prio, std_priority_i};
	assign pend     = interrupt_enable_reg_i[XINT_IE_ALL_POS] ?
		(flag_all & en_all) : 8'h00;
	assign hi_pend  = pend & prio_all;
	// high level first, then lowest index inside the level
	assign win      = (|hi_pend) ? xint_first(hi_pend) : xint_first(pend);

	// control, port and request state
	always_comb begin
		next_st = st;
		// byte writes to the control register; flags go to the detectors
		if (ctrl_byte_wr) begin
			next_st.trig = {sfr_wdata_i[XINT_EXT_IRQ_INPUT_3_TRIG_POS], sfr_wdata_i[XINT_EXT_IRQ_INPUT_2_TRIG_POS]};
			next_st.en   = {sfr_wdata_i[XINT_EXT_IRQ_INPUT_3_EN_POS], sfr_wdata_i[XINT_EXT_IRQ_INPUT_2_EN_POS]};
			next_st.prio = {sfr_wdata_i[XINT_EXT_IRQ_INPUT_3_PRIO_POS], sfr_wdata_i[XINT_EXT_IRQ_INPUT_2_PRIO_POS]};
		end
		// single-bit writes to the control register
		if (ctrl_bit_wr) begin
			unique case (int'(bit_sel))
				XINT_EXT_IRQ_INPUT_2_TRIG_POS: next_st.trig[0] = bit_wdata_i;
				XINT_EXT_IRQ_INPUT_2_EN_POS:   next_st.en[0]   = bit_wdata_i;
				XINT_EXT_IRQ_INPUT_2_PRIO_POS: next_st.prio[0] = bit_wdata_i;
				XINT_EXT_IRQ_INPUT_3_TRIG_POS: next_st.trig[1] = bit_wdata_i;
				XINT_EXT_IRQ_INPUT_3_EN_POS:   next_st.en[1]   = bit_wdata_i;
				XINT_EXT_IRQ_INPUT_3_PRIO_POS: next_st.prio[1] = bit_wdata_i;
				default:            next_st.trig    = next_st.trig;          // flag bits
			endcase
		end
		// port latch: only the low nibble exists
		if (port_byte_wr) begin
			next_st.latch = sfr_wdata_i[3:0];
		end
		if (port_bit_wr && !bit_sel[2]) begin
			next_st.latch[bit_sel[1:0]] = bit_wdata_i;
		end
		// quasi-bidirectional: a 0 pulls hard, a 1 leaves the weak pull-up
		next_st.drive_low = ~next_st.latch;
		// byte reads: port reads the pins, upper nibble reads zero
		next_st.rdata = XINT_RST_BYTE;
		if (sfr_rd_i && sfr_addr_i == XINT_ADDR_CONTROL) begin
			next_st.rdata = ctrl_view;
		end else if (sfr_rd_i && sfr_addr_i == XINT_ADDR_PORT) begin
			next_st.rdata = {XINT_PORT_UNUSED, extra_io_port_i};
		end
		next_st.ext01 = flags[1:0];
		// request presented one cycle after the flag is seen
		next_st.req  = |pend;
		next_st.high = |hi_pend;
		next_st.src  = win;
		next_st.vec  = xint_vector(win);
	end

	// ports come out of reset high, vector at 03, all else cleared
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '{prio: XINT_RST_CTRL2, en: XINT_RST_CTRL2, trig: XINT_RST_CTRL2,
				latch: XINT_RST_PORT, drive_low: ~XINT_RST_PORT,
				rdata: XINT_RST_BYTE, ext01: 2'h0, req: 1'b0, high: 1'b0,
				src: XINT_SRC_EXT0, vec: 8'h03};
		end else begin
			st <= next_st;
		end
	end

	assign sfr_rdata_o        = st.rdata;
	assign ext01_flag_o       = st.ext01;
	assign irq_req_o          = st.req;
	assign irq_high_o         = st.high;
	assign irq_src_o          = st.src;
	assign irq_vector_o       = st.vec;
	assign extra_io_port_o    = st.latch;
	assign extra_io_port_oe_o = st.drive_low;
endmodule // xint_top
`default_nettype wire

// File: tb/xint_chk_properties.sv
// port-level assertions for the extra interrupt and port block
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module xint_chk
	import xint_pkg::*;
(
	input wire logic       clock_i,
	input wire logic       arst_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic       sfr_wr_i,
	input wire logic       sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic       bit_wr_i,
	input wire logic       ext0_n_i,
	input wire logic [7:0] interrupt_enable_reg_i,
	input wire logic [7:0] timer_control_reg_i,
	input wire logic [5:0] std_priority_i,
	input wire logic       irq_req_o,
	input wire logic       irq_high_o,
	input wire logic [2:0] irq_src_o,
	input wire logic [7:0] irq_vector_o,
	input wire logic [3:0] extra_io_port_o,
	input wire logic [3:0] extra_io_port_oe_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	logic ext0_top;
	// ext0 low in level mode, enabled and high: must win once held for three cycles
	assign ext0_top = !ext0_n_i && !timer_control_reg_i[0] && interrupt_enable_reg_i[7]
		&& interrupt_enable_reg_i[0] && std_priority_i[0];
	a_rdata_idle: assert property (!$past(sfr_rd_i) |-> sfr_rdata_o == 8'h00)
		else $error("read data not idle");
	a_upper_zero: assert property ($past(sfr_rd_i && sfr_addr_i == XINT_ADDR_PORT)
		|-> sfr_rdata_o[7:4] == 4'h0) else $error("port upper bits set");
	a_oe_inverse: assert property (extra_io_port_oe_o == ~extra_io_port_o)
		else $error("drive enable wrong");
	a_port_write: assert property (sfr_wr_i && sfr_addr_i == XINT_ADDR_PORT
		&& !bit_wr_i |=> extra_io_port_o == $past(sfr_wdata_i[3:0]))
		else $error("latch wrong");
	// flag bits are masked: hardware may move them between write and read
	a_ctrl_readback: assert property (
		(sfr_wr_i && sfr_addr_i == XINT_ADDR_CONTROL && !bit_wr_i)
		##2 (sfr_rd_i && sfr_addr_i == XINT_ADDR_CONTROL && !sfr_wr_i && !bit_wr_i
		&& !$past(sfr_wr_i) && !$past(bit_wr_i))
		|=> (sfr_rdata_o & 8'hDD) == ($past(sfr_wdata_i, 3) & 8'hDD))
		else $error("control readback wrong");
	a_vector_map: assert property (irq_req_o |-> irq_vector_o == {2'h0, irq_src_o, 3'h3})
		else $error("vector wrong");
	a_global_off: assert property (!$past(interrupt_enable_reg_i[7])
		&& !$past(interrupt_enable_reg_i[7], 2) |-> !irq_req_o)
		else $error("request while disabled");
	a_first_wins: assert property (ext0_top [*3] |=> irq_req_o && irq_high_o
		&& irq_src_o == XINT_SRC_EXT0) else $error("ext0 not chosen");
	c_high_req: cover property (irq_req_o && irq_high_o);
	c_src_last: cover property (irq_req_o && irq_src_o == XINT_SRC_EXT3);
	c_port_read: cover property (sfr_rd_i && sfr_addr_i == XINT_ADDR_PORT);
endmodule // xint_chk
bind xint_top xint_chk i_chk (.*);
`default_nettype wire

// File: tb/xint_far_model.sv
// far-side model: extra port pin wiring and the core's acknowledge
// assumes its inputs change after the rising edge of clock_i
`timescale 1ns/100ps
`default_nettype none
module xint_far_model (
	input  wire logic       clock_i,
	input  wire logic       arst_n_i,
	input  wire logic [3:0] pull_low_i,
	input  wire logic [3:0] oe_i,
	input  wire logic       req_i,
	input  wire logic       ack_on_i,
	output logic      [3:0] pin_o,
	output logic            ack_o
);
	logic [1:0] gap;
	// pull-up wins unless the latch or the outside world pulls low
	assign pin_o = ~(oe_i | pull_low_i);
	// one ack, then a pause so the arbiter outputs can move first
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack_o <= 1'b0;
			gap   <= 2'h0;
		end else begin
			ack_o <= ack_on_i && req_i && gap == 2'h0 && !ack_o;
			gap   <= ack_o ? 2'h3 : gap - {1'b0, gap != 2'h0};
		end
	end
endmodule // xint_far_model
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the extra interrupt and port block
// assumes the far-side model stands in for the pins and the core's ack
`timescale 1ns/100ps
`default_nettype none
module testbench
	import xint_pkg::*;
;
	logic clock_i = 1'b0, arst_n_i = 1'b0, ack_on = 1'b0;
	logic sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, bit_wr_i = 1'b0, bit_wdata_i = 1'b0;
	logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, bit_addr_i = 8'h00, e;
	logic ext0_n_i = 1'b1, ext1_n_i = 1'b1, irq_ack_i, irq_req_o, irq_high_o;
	logic [7:0] interrupt_enable_reg_i = 8'h00, timer_control_reg_i = 8'h00;
	logic [3:0] other_flag_i = 4'h0, pull_low = 4'h0, extra_io_port_i;
	logic [5:0] std_priority_i = 6'h00;
	logic [7:0] sfr_rdata_o, irq_vector_o;
	logic [3:0] extra_io_port_o, extra_io_port_oe_o;
	logic [2:0] irq_src_o;
	logic [1:0] ext01_flag_o;
	int errors = 0, samples_checked = 0;
	always #50 clock_i = ~clock_i;
	xint_top i_dut (.*);
	xint_far_model i_far (.clock_i(clock_i), .arst_n_i(arst_n_i), .pull_low_i(pull_low),
		.oe_i(extra_io_port_oe_o), .req_i(irq_req_o), .ack_on_i(ack_on),
		.pin_o(extra_io_port_i), .ack_o(irq_ack_i));
	task automatic test_done;
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// every strobe stands for exactly one sampling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		#1 sfr_addr_i = a;
		sfr_wdata_i = d;
		sfr_wr_i = 1'b1;
		@(posedge clock_i);
		#1 sfr_wr_i = 1'b0;
	endtask
	task automatic bwr(input logic [7:0] a, input logic v);
		@(posedge clock_i);
		#1 bit_addr_i = a;
		bit_wdata_i = v;
		bit_wr_i = 1'b1;
		@(posedge clock_i);
		#1 bit_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock_i);
		#1 sfr_addr_i = a;
		sfr_rd_i = 1'b1;
		@(posedge clock_i);
		#1 sfr_rd_i = 1'b0;
		chk("read data", exp, sfr_rdata_o);
	endtask
	task automatic wait_req(input logic v);
		int n;
		n = 0;
		while (irq_req_o !== v && n < 50) begin
			@(posedge clock_i);
			#1 n++;
		end
		if (n == 50) begin
			errors++;
			test_done();
		end
	endtask
	// outputs settle two cycles after a cause, so allow three
	task automatic chk_req(input logic [2:0] s, input logic h);
		repeat (3) @(posedge clock_i);
		// step off the edge so outputs are settled and ack_on changes clear of it
		#1 wait_req(1'b1);
		chk("source", {5'h00, s}, {5'h00, irq_src_o});
		chk("priority", {7'h00, h}, {7'h00, irq_high_o});
		chk("vector", {2'h0, s, 3'h3}, irq_vector_o);
	endtask
	initial begin
		repeat (16) @(posedge clock_i);
		#1 arst_n_i = 1'b1;
		chk("port latch", 8'h0F, {4'h0, extra_io_port_o});
		rd(XINT_ADDR_CONTROL, 8'h00);
		rd(8'h55, 8'h00);
		wr(XINT_ADDR_PORT, 8'hFA);
		chk("port latch", 8'h0A, {4'h0, extra_io_port_o});
		chk("drive enable", 8'h05, {4'h0, extra_io_port_oe_o});
		rd(XINT_ADDR_PORT, 8'h0A);
		bwr({XINT_BITBASE_PORT, 3'h2}, 1'b1);
		pull_low = 4'h8;
		rd(XINT_ADDR_PORT, 8'h06);
		pull_low = 4'h0;
		wr(XINT_ADDR_PORT, 8'h0F);
		// set then clear every control bit by its bit address
		e = 8'h00;
		for (int i = 0; i < 8; i++) begin
			bwr({XINT_BITBASE_CTRL, 3'(i)}, 1'b1);
			e[i] = 1'b1;
			rd(XINT_ADDR_CONTROL, e);
		end
		for (int i = 7; i >= 0; i--) begin
			bwr({XINT_BITBASE_CTRL, 3'(i)}, 1'b0);
			e[i] = 1'b0;
			rd(XINT_ADDR_CONTROL, e);
		end
		// edge mode: one request per edge even with the pin left low
		interrupt_enable_reg_i = 8'h80;
		wr(XINT_ADDR_CONTROL, 8'h05);
		pull_low = 4'h4;
		chk_req(3'h6, 1'b0);
		ack_on = 1'b1;
		wait_req(1'b0);
		rd(XINT_ADDR_CONTROL, 8'h05);
		// high level beats polling order; level flag ignores the ack
		ack_on = 1'b0;
		pull_low = 4'h0;
		wr(XINT_ADDR_CONTROL, 8'hC5);
		pull_low = 4'hC;
		chk_req(3'h7, 1'b1);
		ack_on = 1'b1;
		chk_req(3'h7, 1'b1);
		ack_on = 1'b0;
		pull_low = 4'h4;
		chk_req(3'h6, 1'b0);
		ack_on = 1'b1;
		wait_req(1'b0);
		wr(XINT_ADDR_CONTROL, 8'h00);
		pull_low = 4'h8;
		rd(XINT_ADDR_CONTROL, 8'h20);
		chk("request", 8'h00, {7'h00, irq_req_o});
		// all eight pending; drop enables one by one down the order
		ack_on = 1'b0;
		pull_low = 4'hC;
		ext0_n_i = 1'b0;
		ext1_n_i = 1'b0;
		other_flag_i = 4'hF;
		std_priority_i = 6'h3F;
		for (int k = 0; k < 8; k++) begin
			interrupt_enable_reg_i = 8'h80 | ((8'h3F << k) & 8'h3F);
			wr(XINT_ADDR_CONTROL, (k < 7) ? 8'h44 : 8'h40);
			chk_req(3'(k), k < 6);
		end
		// ext0 and ext1 flags: level mode follows the pins, edge mode latches a fall
		ext0_n_i = 1'b1;
		ext1_n_i = 1'b1;
		repeat (2) @(posedge clock_i);
		#1 timer_control_reg_i = 8'h05;
		chk("ext flags", 8'h00, {6'h00, ext01_flag_o});
		ext0_n_i = 1'b0;
		repeat (3) @(posedge clock_i);
		#1 chk("ext flags", 8'h01, {6'h00, ext01_flag_o});
		// reset in mid-run brings latch, drive and control back to their reset values
		wr(XINT_ADDR_PORT, 8'h00);
		pull_low = 4'h0;
		@(posedge clock_i);
		#1 arst_n_i = 1'b0;
		@(posedge clock_i);
		#1 arst_n_i = 1'b1;
		chk("port latch", 8'h0F, {4'h0, extra_io_port_o});
		chk("drive enable", 8'h00, {4'h0, extra_io_port_oe_o});
		chk("request", 8'h00, {7'h00, irq_req_o});
		rd(XINT_ADDR_CONTROL, 8'h00);
		test_done();
	end
endmodule // testbench
`default_nettype wire
